// >>> wake_pkg.sv
// shared constants for the implant/base wake-up control ends
package wake_pkg;
   // clock and timing
   localparam int CLK_HZ = 100_000_000;
   localparam int CYC_PER_US = CLK_HZ / 1_000_000;
   localparam int WAKE_MIN_US = 1500;
   localparam int WAKE_MIN_CYC = WAKE_MIN_US * CYC_PER_US;
   localparam int OSC_HZ = 25_000;
   localparam int OSC_CYC = CLK_HZ / OSC_HZ;
   localparam int SNIFF_US = 200;
   localparam int SNIFF_CYC = SNIFF_US * CYC_PER_US;
   localparam int RESP_GAP_MIN_CYC = 2000;
   localparam int RESP_TX_CYC = 500;
   localparam int OOK_BIT_CYC = 100;
   localparam int WAKE_HOLD_US = 1600;
   localparam int WAKE_HOLD_CYC = WAKE_HOLD_US * CYC_PER_US;
   localparam int STROBE_US = 10;
   localparam int STROBE_CYC = STROBE_US * CYC_PER_US;
   localparam int CNT_W = 20;
   // register port shape
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;
   // device registers
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STROBE = 4'h1;
   localparam logic [3:0] REG_INTERVAL = 4'h2;
   localparam logic [3:0] REG_STATUS = 4'h3;
   localparam int CTRL_FLAG_BIT = 0;
   localparam int CTRL_WAKE_BIT = 1;
   localparam int CTRL_SESSION_BIT = 2;
   localparam int CTRL_STOP_BIT = 3;
   localparam int STROBE_OSC_BIT = 0;
   localparam int STROBE_PIN_BIT = 1;
   localparam logic [7:0] INTERVAL_RST = 8'h19;
   localparam logic [7:0] OOK_PATTERN = 8'hB2;
   localparam logic [15:0] LFSR_SEED = 16'hACE1;
   // host registers
   localparam logic [3:0] HREG_CTRL = 4'h0;
   localparam logic [3:0] HREG_ADDR = 4'h1;
   localparam logic [3:0] HREG_WDATA = 4'h2;
   localparam logic [3:0] HREG_RDREQ = 4'h3;
   localparam logic [3:0] HREG_STATUS = 4'h4;
   localparam logic [3:0] HREG_RDATA = 4'h5;
   localparam int HCTRL_STRAP_BIT = 0;
   localparam int HCTRL_WAKE_BIT = 1;
   localparam int HCTRL_STROBE_BIT = 2;
   // device states
   typedef enum logic [2:0] {
      ST_POWERUP, ST_SLEEP, ST_SNIFF, ST_IDLE, ST_RESPOND, ST_BASE_IDLE, ST_BASE_WAKE, ST_SESSION
   } dev_state_t;
endpackage : wake_pkg

// >>> wake_link_if.sv
// link between the implant/base transceiver control and its host
`timescale 1ns/100ps
interface wake_link_if;
   logic implant_base_select;
   logic wake_pin;
   logic [3:0] reg_addr;
   logic [7:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [7:0] reg_rdata;
   modport dev (input implant_base_select, input wake_pin, input reg_addr, input reg_wdata,
                input reg_wr, input reg_rd, output reg_rdata);
   modport host (output implant_base_select, output wake_pin, output reg_addr, output reg_wdata,
                 output reg_wr, output reg_rd, input reg_rdata);
endinterface : wake_link_if

// >>> implant_wake_ctrl.sv
// transceiver end: mode strap, sleep, strobed sniff, wake-up and response sequencing
// Notes on behaviour
// - strap low implant, high base at power-up
// - implant mode sleeps until a wake event
// - base mode comes up idle, controller running
// - wake pulse over 1.5 ms wakes to idle
// - host holds wake pin over 1.5 ms
// - direct wake sets respond-or-idle flag to one
// - flag one idles, zero sends wake responses
// - host writing flag zero starts responses
// - host sets modulation, channel before clearing flag
// - base host checks channel, programs link first
// - base wake write drives ook and 400-MHz
// - wake receiver strobed by oscillator, pin, both
// - valid wake message starts responses and listening
// - randomized gap between response packets
// - base host starts session by control write
// - emergency wake needs no channel check
// - internal 25-kHz strobe generator
// - idle: controller runs, radio blocks off
//
// The register addresses and the plain strobed port were decided locally.
`timescale 1ns/100ps
module implant_wake_ctrl #(
   parameter int WAKE_MIN_CYC = wake_pkg::WAKE_MIN_CYC,
   parameter int SNIFF_CYC = wake_pkg::SNIFF_CYC
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // link to host
   wake_link_if.dev link,
   // radio side
   input wire logic wake_msg_ok_in,
   output logic mode_base_out,
   output logic mac_run_out,
   output logic wake_rx_on_out,
   output logic tx400_en_out,
   output logic rx400_en_out,
   output logic ook_out,
   output logic resp_pulse_out
);
   import wake_pkg::*;

   function automatic logic [CNT_W-1:0] rand_gap(input logic [15:0] seed);
      rand_gap = CNT_W'(RESP_GAP_MIN_CYC) + {{(CNT_W-14){1'b0}}, seed[7:0], 6'h00};
   endfunction : rand_gap

   dev_state_t state_r, state_nxt;
   logic [1:0] strap_s_r, strap_s_nxt;
   logic [1:0] pu_r, pu_nxt;
   logic [1:0] pin_s_r, pin_s_nxt;
   logic [1:0] msg_s_r, msg_s_nxt;
   logic pin_d_r, pin_d_nxt;
   logic mode_base_r, mode_base_nxt;
   logic flag_r, flag_nxt;
   logic [1:0] strobe_src_r, strobe_src_nxt;
   logic [7:0] interval_r, interval_nxt;
   logic [7:0] rdata_r, rdata_nxt;
   logic [CNT_W-1:0] pin_cnt_r, pin_cnt_nxt;
   logic [CNT_W-1:0] osc_cnt_r, osc_cnt_nxt;
   logic [7:0] tick_cnt_r, tick_cnt_nxt;
   logic [CNT_W-1:0] tmr_r, tmr_nxt;
   logic [15:0] lfsr_r, lfsr_nxt;
   logic [2:0] ook_idx_r, ook_idx_nxt;
   logic ook_r, ook_nxt;
   logic burst_r, burst_nxt;
   logic resp_pulse_r, resp_pulse_nxt;
   logic wr_ctrl;
   logic pin_rise;
   logic pin_fall;

   always_comb
   begin
      strap_s_nxt = {strap_s_r[0], link.implant_base_select};
      pu_nxt = {pu_r[0], 1'b1};
      pin_s_nxt = {pin_s_r[0], link.wake_pin};
      msg_s_nxt = {msg_s_r[0], wake_msg_ok_in};
      pin_d_nxt = pin_s_r[1];
      pin_rise = pin_s_r[1] && !pin_d_r;
      pin_fall = !pin_s_r[1] && pin_d_r;
      wr_ctrl = link.reg_wr && (link.reg_addr == REG_CTRL);
      state_nxt = state_r;
      mode_base_nxt = mode_base_r;
      flag_nxt = flag_r;
      strobe_src_nxt = strobe_src_r;
      interval_nxt = interval_r;
      rdata_nxt = rdata_r;
      pin_cnt_nxt = pin_cnt_r;
      osc_cnt_nxt = osc_cnt_r;
      tick_cnt_nxt = tick_cnt_r;
      tmr_nxt = tmr_r;
      lfsr_nxt = {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
      ook_idx_nxt = ook_idx_r;
      ook_nxt = 1'b0;
      burst_nxt = burst_r;
      resp_pulse_nxt = 1'b0;

      // register port, read data valid one cycle after the strobe
      if (link.reg_rd)
      begin
         case (link.reg_addr)
            REG_CTRL: rdata_nxt = {7'h00, flag_r};
            REG_STROBE: rdata_nxt = {6'h00, strobe_src_r};
            REG_INTERVAL: rdata_nxt = interval_r;
            REG_STATUS: rdata_nxt = {mode_base_r, flag_r, 3'h0, state_r};
            default: rdata_nxt = 8'h00;
         endcase
      end
      if (link.reg_wr && link.reg_addr == REG_STROBE)
         strobe_src_nxt = link.reg_wdata[1:0];
      if (link.reg_wr && link.reg_addr == REG_INTERVAL)
         interval_nxt = link.reg_wdata;
      if (wr_ctrl)
         flag_nxt = link.reg_wdata[CTRL_FLAG_BIT];

      // wake pin high time, saturating just past the threshold
      if (!pin_s_r[1])
         pin_cnt_nxt = '0;
      else if (pin_cnt_r <= CNT_W'(WAKE_MIN_CYC))
         pin_cnt_nxt = pin_cnt_r + CNT_W'(1);

      case (state_r)
         ST_POWERUP:
         begin
            // strap seen through the synchroniser, caught once and then held
            mode_base_nxt = strap_s_r[1];
            state_nxt = !pu_r[1] ? ST_POWERUP : strap_s_r[1] ? ST_BASE_IDLE : ST_SLEEP;
         end
         ST_SLEEP, ST_SNIFF:
         begin
            if (pin_fall && pin_cnt_r > CNT_W'(WAKE_MIN_CYC))
            begin
               state_nxt = ST_IDLE;
               flag_nxt = 1'b1;
            end
            else if (state_r == ST_SLEEP)
            begin
               // strobe oscillator only runs while asleep
               if (strobe_src_r[STROBE_OSC_BIT])
               begin
                  if (osc_cnt_r >= CNT_W'(OSC_CYC - 1))
                  begin
                     osc_cnt_nxt = '0;
                     tick_cnt_nxt = tick_cnt_r + 8'h01;
                  end
                  else
                     osc_cnt_nxt = osc_cnt_r + CNT_W'(1);
               end
               if ((strobe_src_r[STROBE_OSC_BIT] && tick_cnt_r >= interval_r && interval_r != 8'h00)
                   || (strobe_src_r[STROBE_PIN_BIT] && pin_rise))
               begin
                  state_nxt = ST_SNIFF;
                  tmr_nxt = CNT_W'(SNIFF_CYC);
                  tick_cnt_nxt = 8'h00;
                  osc_cnt_nxt = '0;
               end
            end
            else if (msg_s_r[1])
            begin
               state_nxt = ST_RESPOND;
               tmr_nxt = rand_gap(lfsr_r);
               burst_nxt = 1'b0;
            end
            else if (tmr_r == '0)
               state_nxt = ST_SLEEP;
            else
               tmr_nxt = tmr_r - CNT_W'(1);
         end
         ST_IDLE:
         begin
            // flag cleared by the host; a direct wake already set it
            if (wr_ctrl && link.reg_wdata[CTRL_SESSION_BIT])
               state_nxt = ST_SESSION;
            else if (!flag_r)
            begin
               state_nxt = ST_RESPOND;
               tmr_nxt = rand_gap(lfsr_r);
               burst_nxt = 1'b0;
            end
         end
         ST_RESPOND:
         begin
            if (wr_ctrl && link.reg_wdata[CTRL_SESSION_BIT])
               state_nxt = ST_SESSION;
            else if (wr_ctrl && link.reg_wdata[CTRL_FLAG_BIT])
               state_nxt = ST_IDLE;
            else if (tmr_r != '0)
               tmr_nxt = tmr_r - CNT_W'(1);
            else if (!burst_r)
            begin
               burst_nxt = 1'b1;
               resp_pulse_nxt = 1'b1;
               tmr_nxt = CNT_W'(RESP_TX_CYC);
            end
            else
            begin
               // new random gap each time so several implants drift apart
               burst_nxt = 1'b0;
               tmr_nxt = rand_gap(lfsr_r);
            end
         end
         ST_BASE_IDLE:
         begin
            if (wr_ctrl && link.reg_wdata[CTRL_WAKE_BIT])
            begin
               state_nxt = ST_BASE_WAKE;
               tmr_nxt = CNT_W'(OOK_BIT_CYC - 1);
               ook_idx_nxt = 3'h0;
            end
            else if (wr_ctrl && link.reg_wdata[CTRL_SESSION_BIT])
               state_nxt = ST_SESSION;
         end
         ST_BASE_WAKE:
         begin
            ook_nxt = OOK_PATTERN[ook_idx_r];
            if (tmr_r == '0)
            begin
               tmr_nxt = CNT_W'(OOK_BIT_CYC - 1);
               ook_idx_nxt = ook_idx_r + 3'h1;
            end
            else
               tmr_nxt = tmr_r - CNT_W'(1);
            if (wr_ctrl && link.reg_wdata[CTRL_SESSION_BIT])
               state_nxt = ST_SESSION;
            else if (wr_ctrl && link.reg_wdata[CTRL_STOP_BIT])
               state_nxt = ST_BASE_IDLE;
         end
         ST_SESSION:
         begin
            if (wr_ctrl && link.reg_wdata[CTRL_STOP_BIT])
               state_nxt = mode_base_r ? ST_BASE_IDLE : ST_IDLE;
         end
         default: state_nxt = ST_POWERUP;
      endcase
   end

   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         state_r <= ST_POWERUP;
         strap_s_r <= 2'h0;
         pu_r <= 2'h0;
         pin_s_r <= 2'h0;
         msg_s_r <= 2'h0;
         pin_d_r <= 1'b0;
         mode_base_r <= 1'b0;
         flag_r <= 1'b1;
         strobe_src_r <= 2'h0;
         interval_r <= INTERVAL_RST;
         rdata_r <= 8'h00;
         pin_cnt_r <= '0;
         osc_cnt_r <= '0;
         tick_cnt_r <= 8'h00;
         tmr_r <= '0;
         lfsr_r <= LFSR_SEED;
         ook_idx_r <= 3'h0;
         ook_r <= 1'b0;
         burst_r <= 1'b0;
         resp_pulse_r <= 1'b0;
         mode_base_out <= 1'b0;
         mac_run_out <= 1'b0;
         wake_rx_on_out <= 1'b0;
         tx400_en_out <= 1'b0;
         rx400_en_out <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         strap_s_r <= strap_s_nxt;
         pu_r <= pu_nxt;
         pin_s_r <= pin_s_nxt;
         msg_s_r <= msg_s_nxt;
         pin_d_r <= pin_d_nxt;
         mode_base_r <= mode_base_nxt;
         flag_r <= flag_nxt;
         strobe_src_r <= strobe_src_nxt;
         interval_r <= interval_nxt;
         rdata_r <= rdata_nxt;
         pin_cnt_r <= pin_cnt_nxt;
         osc_cnt_r <= osc_cnt_nxt;
         tick_cnt_r <= tick_cnt_nxt;
         tmr_r <= tmr_nxt;
         lfsr_r <= lfsr_nxt;
         ook_idx_r <= ook_idx_nxt;
         ook_r <= ook_nxt;
         burst_r <= burst_nxt;
         resp_pulse_r <= resp_pulse_nxt;
         // radio enables follow the next state, so they stay flop outputs
         mode_base_out <= mode_base_nxt;
         mac_run_out <= state_nxt inside {ST_IDLE, ST_RESPOND, ST_BASE_IDLE, ST_BASE_WAKE, ST_SESSION};
         wake_rx_on_out <= state_nxt == ST_SNIFF;
         tx400_en_out <= state_nxt == ST_BASE_WAKE || (state_nxt == ST_RESPOND && burst_nxt);
         rx400_en_out <= state_nxt inside {ST_BASE_WAKE, ST_SESSION}
                         || (state_nxt == ST_RESPOND && !burst_nxt);
      end
   end

   assign link.reg_rdata = rdata_r;
   assign ook_out = ook_r;
   assign resp_pulse_out = resp_pulse_r;
endmodule : implant_wake_ctrl

// >>> host_wake_ctrl.sv
// host end: strap level, wake pin pulses and register forwarding for software
`timescale 1ns/100ps
module host_wake_ctrl #(
   parameter int WAKE_HOLD_CYC = wake_pkg::WAKE_HOLD_CYC
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // software port
   input wire logic [wake_pkg::ADDR_W-1:0] sw_addr_in,
   input wire logic [wake_pkg::DATA_W-1:0] sw_wdata_in,
   input wire logic sw_wr_in,
   input wire logic sw_rd_in,
   output logic [wake_pkg::DATA_W-1:0] sw_rdata_out,
   // link to transceiver
   wake_link_if.host link
);
   import wake_pkg::*;

   logic strap_r, strap_nxt;
   logic pin_r, pin_nxt;
   logic [CNT_W-1:0] pulse_cnt_r, pulse_cnt_nxt;
   logic [3:0] fwd_addr_r, fwd_addr_nxt;
   logic [3:0] addr_r, addr_nxt;
   logic [7:0] wdata_r, wdata_nxt;
   logic wr_r, wr_nxt;
   logic rd_r, rd_nxt;
   logic rd_wait_r, rd_wait_nxt;
   logic rd_valid_r, rd_valid_nxt;
   logic [7:0] rdata_r, rdata_nxt;
   logic [7:0] sw_rdata_nxt;
   logic hwr;

   always_comb
   begin
      hwr = sw_wr_in;
      strap_nxt = strap_r;
      pin_nxt = pin_r;
      pulse_cnt_nxt = pulse_cnt_r;
      fwd_addr_nxt = fwd_addr_r;
      addr_nxt = addr_r;
      wdata_nxt = wdata_r;
      wr_nxt = 1'b0;
      rd_nxt = 1'b0;
      rd_wait_nxt = rd_r;
      rd_valid_nxt = rd_valid_r;
      rdata_nxt = rdata_r;
      sw_rdata_nxt = 8'h00;
      if (pulse_cnt_r != '0)
         pulse_cnt_nxt = pulse_cnt_r - CNT_W'(1);
      else
         pin_nxt = 1'b0;
      if (hwr && sw_addr_in == HREG_CTRL)
      begin
         strap_nxt = sw_wdata_in[HCTRL_STRAP_BIT];
         // a new pulse is ignored while one is still on the pin
         if (pulse_cnt_r == '0 && !pin_r && sw_wdata_in[HCTRL_WAKE_BIT])
         begin
            pin_nxt = 1'b1;
            pulse_cnt_nxt = CNT_W'(WAKE_HOLD_CYC);
         end
         else if (pulse_cnt_r == '0 && !pin_r && sw_wdata_in[HCTRL_STROBE_BIT])
         begin
            pin_nxt = 1'b1;
            pulse_cnt_nxt = CNT_W'(STROBE_CYC);
         end
      end
      if (hwr && sw_addr_in == HREG_ADDR)
         fwd_addr_nxt = sw_wdata_in[3:0];
      if (hwr && sw_addr_in == HREG_WDATA)
      begin
         addr_nxt = fwd_addr_r;
         wdata_nxt = sw_wdata_in;
         wr_nxt = 1'b1;
      end
      if (hwr && sw_addr_in == HREG_RDREQ)
      begin
         addr_nxt = fwd_addr_r;
         rd_nxt = 1'b1;
         rd_valid_nxt = 1'b0;
      end
      if (rd_wait_r)
      begin
         rdata_nxt = link.reg_rdata;
         rd_valid_nxt = 1'b1;
      end
      if (sw_rd_in)
      begin
         case (sw_addr_in)
            HREG_CTRL: sw_rdata_nxt = {5'h00, 1'b0, pin_r, strap_r};
            HREG_ADDR: sw_rdata_nxt = {4'h0, fwd_addr_r};
            HREG_STATUS: sw_rdata_nxt = {6'h00, pin_r, rd_valid_r};
            HREG_RDATA: sw_rdata_nxt = rdata_r;
            default: sw_rdata_nxt = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         strap_r <= 1'b0;
         pin_r <= 1'b0;
         pulse_cnt_r <= '0;
         fwd_addr_r <= 4'h0;
         addr_r <= 4'h0;
         wdata_r <= 8'h00;
         wr_r <= 1'b0;
         rd_r <= 1'b0;
         rd_wait_r <= 1'b0;
         rd_valid_r <= 1'b0;
         rdata_r <= 8'h00;
         sw_rdata_out <= 8'h00;
      end
      else
      begin
         strap_r <= strap_nxt;
         pin_r <= pin_nxt;
         pulse_cnt_r <= pulse_cnt_nxt;
         fwd_addr_r <= fwd_addr_nxt;
         addr_r <= addr_nxt;
         wdata_r <= wdata_nxt;
         wr_r <= wr_nxt;
         rd_r <= rd_nxt;
         rd_wait_r <= rd_wait_nxt;
         rd_valid_r <= rd_valid_nxt;
         rdata_r <= rdata_nxt;
         sw_rdata_out <= sw_rdata_nxt;
      end
   end

   assign link.implant_base_select = strap_r;
   assign link.wake_pin = pin_r;
   assign link.reg_addr = addr_r;
   assign link.reg_wdata = wdata_r;
   assign link.reg_wr = wr_r;
   assign link.reg_rd = rd_r;
endmodule : host_wake_ctrl

// >>> wake_link_checker.sv
// concurrent checks on the link between host end and transceiver end
`timescale 1ns/100ps
module wake_link_checker #(
   parameter int WAKE_HOLD_CYC = 1600
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // link signals
   input wire logic implant_base_select,
   input wire logic wake_pin,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata
);
   import wake_pkg::*;
   logic [1:0] pcnt_r, pcnt_nxt;
   logic mode_r, mode_nxt, touched_r, touched_nxt, rdp_r, rdp_nxt;
   logic [2:0] last_r, last_nxt;
   logic [19:0] hi_r, hi_nxt;
   // strap copy taken as the transceiver takes it
   always_comb
   begin
      pcnt_nxt = (pcnt_r == 2'h3) ? pcnt_r : pcnt_r + 2'h1;
      mode_nxt = (pcnt_r == 2'h2) ? implant_base_select : mode_r;
      touched_nxt = touched_r | reg_wr | wake_pin;
      rdp_nxt = reg_rd && reg_addr == REG_STATUS;
      last_nxt = rdp_r ? reg_rdata[2:0] : last_r;
      hi_nxt = wake_pin ? hi_r + 20'h1 : 20'h0;
   end
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         pcnt_r <= 2'h0;
         mode_r <= 1'h0;
         touched_r <= 1'h0;
         rdp_r <= 1'h0;
         last_r <= 3'h0;
         hi_r <= 20'h0;
      end
      else
      begin
         pcnt_r <= pcnt_nxt;
         mode_r <= mode_nxt;
         touched_r <= touched_nxt;
         rdp_r <= rdp_nxt;
         last_r <= last_nxt;
         hi_r <= hi_nxt;
      end
   end
   default clocking @(posedge clk_in);
   endclocking
   default disable iff (rst_in);
   sequence s_status_read;
      reg_rd && reg_addr == REG_STATUS;
   endsequence
   sequence s_fresh_read;
      reg_rd && reg_addr == REG_STATUS && pcnt_r == 2'h3 && !touched_r;
   endsequence
   sequence s_long_fall;
      $fell(wake_pin) && hi_r >= WAKE_HOLD_CYC - 1 && !mode_r && (last_r == 3'h1 || last_r == 3'h2);
   endsequence
   sequence s_flag_clear;
      reg_wr && reg_addr == REG_CTRL && reg_wdata[3:0] == 4'h0 && last_r == 3'h3 && !mode_r;
   endsequence
   sequence s_base_go;
      reg_wr && reg_addr == REG_CTRL && reg_wdata[3:1] == 3'h1 && last_r == 3'h5 && mode_r;
   endsequence
   a_powerup_sleep: assert property (s_fresh_read and !mode_r |=> reg_rdata[2:0] == 3'h1)
      else $error("implant did not power up asleep");
   a_powerup_idle: assert property (s_fresh_read and mode_r |=> reg_rdata[2:0] == 3'h5)
      else $error("base did not power up idle");
   a_mode_held: assert property (s_status_read and pcnt_r == 2'h3 |=> reg_rdata[7] == mode_r)
      else $error("mode bit differs from strap taken at power-up");
   a_direct_wake: assert property (s_long_fall ##[8:400] s_status_read |=> reg_rdata[6:0] == 7'h43)
      else $error("long wake pulse did not give idle with flag set");
   a_flag_clear: assert property (s_flag_clear ##[1:100] s_status_read |=> reg_rdata[6:0] == 7'h04)
      else $error("clearing flag in idle did not start responses");
   a_base_wake: assert property (s_base_go ##[1:1000] s_status_read |=> reg_rdata[2:0] == 3'h6)
      else $error("base wake write did not enter wake state");
   a_wake_pulse_len: assert property ($fell(wake_pin) && hi_r > STROBE_CYC + 2
      |-> hi_r >= WAKE_HOLD_CYC - 2 && hi_r <= WAKE_HOLD_CYC + 2)
      else $error("direct wake pulse has wrong length");
   a_strobe_len: assert property ($fell(wake_pin) && hi_r < WAKE_HOLD_CYC - 2
      |-> hi_r >= STROBE_CYC - 2 && hi_r <= STROBE_CYC + 2)
      else $error("strobe pulse has wrong length");
endmodule : wake_link_checker

// >>> tb_top.sv
// self-checking bench: host end and transceiver end joined over the link
`timescale 1ns/100ps
module tb_top;
   import wake_pkg::*;
   // strobe kept under wake threshold
   localparam int DEV_MIN = 1500;
   localparam int HOST_HOLD = 1600;
   localparam int SNIFF = 20;
   localparam int GAP_LO = RESP_GAP_MIN_CYC + RESP_TX_CYC - 1;
   localparam int GAP_HI = RESP_GAP_MIN_CYC + 255 * 64 + RESP_TX_CYC + 3;
   localparam int TIMEOUT = 100000;
   logic clk_in, rst_host, rst_dev, sw_wr, sw_rd, msg_ok;
   logic [3:0] sw_addr;
   logic [7:0] sw_wdata, sw_rdata, d;
   logic mode_base, mac_run, rx_on, tx400, rx400, ook, resp;
   int n_mismatch, compares, cyc, n0, n1, n2;
   wake_link_if u_wake_link_if ();
   host_wake_ctrl #(.WAKE_HOLD_CYC(HOST_HOLD)) u_host_wake_ctrl (.clk_in(clk_in), .rst_in(rst_host),
      .sw_addr_in(sw_addr), .sw_wdata_in(sw_wdata), .sw_wr_in(sw_wr), .sw_rd_in(sw_rd),
      .sw_rdata_out(sw_rdata), .link(u_wake_link_if));
   implant_wake_ctrl #(.WAKE_MIN_CYC(DEV_MIN), .SNIFF_CYC(SNIFF)) u_implant_wake_ctrl (.clk_in(clk_in),
      .rst_in(rst_dev), .link(u_wake_link_if), .wake_msg_ok_in(msg_ok), .mode_base_out(mode_base),
      .mac_run_out(mac_run), .wake_rx_on_out(rx_on), .tx400_en_out(tx400), .rx400_en_out(rx400),
      .ook_out(ook), .resp_pulse_out(resp));
   wake_link_checker #(.WAKE_HOLD_CYC(HOST_HOLD)) u_wake_link_checker (.clk_in(clk_in), .rst_in(rst_dev),
      .implant_base_select(u_wake_link_if.implant_base_select), .wake_pin(u_wake_link_if.wake_pin),
      .reg_addr(u_wake_link_if.reg_addr), .reg_wdata(u_wake_link_if.reg_wdata),
      .reg_wr(u_wake_link_if.reg_wr), .reg_rd(u_wake_link_if.reg_rd), .reg_rdata(u_wake_link_if.reg_rdata));
   initial
   begin
      clk_in = 1'h0;
      forever #5 clk_in = ~clk_in;
   end
   function automatic logic [7:0] st(input logic m, input logic f, input dev_state_t s);
      return {m, f, 3'h0, s};
   endfunction : st
   task automatic end_of_test;
      $display("compares %0d n_mismatch %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : end_of_test
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("[FAIL] %0t byte %h expected %h", $time, got, exp);
      end
   endtask : chk8
   task automatic chk1(input logic got, input logic exp);
      compares++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("[FAIL] %0t bit %b expected %b", $time, got, exp);
      end
   endtask : chk1
   task automatic sw_write(input logic [3:0] a, input logic [7:0] v);
      @(posedge clk_in);
      sw_addr <= a;
      sw_wdata <= v;
      sw_wr <= 1'h1;
      @(posedge clk_in);
      sw_wr <= 1'h0;
   endtask : sw_write
   task automatic sw_read(input logic [3:0] a);
      @(posedge clk_in);
      sw_addr <= a;
      sw_rd <= 1'h1;
      @(posedge clk_in);
      sw_rd <= 1'h0;
      #1;
      d = sw_rdata;
   endtask : sw_read
   task automatic dev_wr(input logic [3:0] a, input logic [7:0] v);
      sw_write(HREG_ADDR, a);
      sw_write(HREG_WDATA, v);
   endtask : dev_wr
   task automatic dev_rd(input logic [3:0] a);
      sw_write(HREG_ADDR, a);
      sw_write(HREG_RDREQ, 8'h00);
      repeat (3) @(posedge clk_in);
      sw_read(HREG_RDATA);
   endtask : dev_rd
   task automatic dev_reset;
      @(posedge clk_in);
      rst_dev <= 1'h1;
      repeat (2) @(posedge clk_in);
      rst_dev <= 1'h0;
      repeat (10) @(posedge clk_in);
   endtask : dev_reset
   task automatic wait_pin_idle;
      int k;
      k = 0;
      do
      begin
         sw_read(HREG_STATUS);
         k++;
      end
      while (d[1] !== 1'h0 && k < 2000);
      chk1(d[1], 1'h0);
   endtask : wait_pin_idle
   task automatic wait_rx(input logic v, output int n);
      n = 0;
      while (rx_on !== v && n < 6000)
      begin
         @(negedge clk_in);
         n++;
      end
   endtask : wait_rx
   task automatic wait_pulse(output int n);
      n = 0;
      do
      begin
         @(negedge clk_in);
         n++;
      end
      while (resp !== 1'h1 && n < 20000);
   endtask : wait_pulse
   always @(posedge clk_in)
   begin
      cyc++;
      if (cyc == TIMEOUT)
      begin
         n_mismatch++;
         $display("[FAIL] %0t run did not finish in time", $time);
         end_of_test();
      end
   end
   initial
   begin
      sw_addr = 4'h0;
      sw_wdata = 8'h00;
      sw_wr = 1'h0;
      sw_rd = 1'h0;
      msg_ok = 1'h0;
      rst_host = 1'h1;
      rst_dev = 1'h1;
      repeat (2) @(posedge clk_in);
      rst_host <= 1'h0;
      rst_dev <= 1'h0;
      repeat (10) @(posedge clk_in);
      // implant power-up, defaults, unmapped place
      dev_rd(REG_STATUS);
      chk8(d, st(1'h0, 1'h1, ST_SLEEP));
      chk1(mac_run, 1'h0);
      dev_rd(REG_INTERVAL);
      chk8(d, INTERVAL_RST);
      dev_rd(REG_STROBE);
      chk8(d, 8'h00);
      dev_rd(4'hA);
      chk8(d, 8'h00);
      // short pin strobe: one sniff window, then back to sleep
      dev_wr(REG_STROBE, 8'h02);
      sw_write(HREG_CTRL, 8'h04);
      wait_rx(1'h1, n0);
      wait_rx(1'h0, n1);
      chk1(n1 >= SNIFF - 1 && n1 <= SNIFF + 1, 1'h1);
      wait_pin_idle();
      dev_rd(REG_STATUS);
      chk8(d, st(1'h0, 1'h1, ST_SLEEP));
      // direct wake with flag cleared first: wake sets it again
      dev_wr(REG_CTRL, 8'h00);
      sw_write(HREG_CTRL, 8'h02);
      wait_pin_idle();
      repeat (10) @(posedge clk_in);
      dev_rd(REG_STATUS);
      chk8(d, st(1'h0, 1'h1, ST_IDLE));
      chk1(mac_run, 1'h1);
      chk1(rx_on | tx400 | rx400 | ook, 1'h0);
      // clearing the flag starts randomly spaced responses
      dev_wr(REG_CTRL, 8'h00);
      dev_rd(REG_STATUS);
      chk8(d, st(1'h0, 1'h0, ST_RESPOND));
      wait_pulse(n0);
      repeat (10) @(negedge clk_in);
      chk1(tx400, 1'h1);
      repeat (590) @(negedge clk_in);
      chk1(tx400, 1'h0);
      chk1(rx400, 1'h1);
      wait_pulse(n1);
      wait_pulse(n2);
      n1 = n1 + 600;
      chk1(n1 >= GAP_LO && n1 <= GAP_HI, 1'h1);
      chk1(n2 >= GAP_LO && n2 <= GAP_HI, 1'h1);
      chk1(n1 != n2, 1'h1);
      dev_wr(REG_CTRL, 8'h01);
      dev_rd(REG_STATUS);
      chk8(d, st(1'h0, 1'h1, ST_IDLE));
      chk1(tx400, 1'h0);
      // fresh power-up: oscillator strobes, then a valid wake message
      dev_reset();
      dev_wr(REG_INTERVAL, 8'h01);
      dev_wr(REG_STROBE, 8'h01);
      wait_rx(1'h1, n0);
      wait_rx(1'h0, n1);
      wait_rx(1'h1, n2);
      chk1(n1 + n2 >= OSC_CYC + SNIFF - 10 && n1 + n2 <= OSC_CYC + SNIFF + 10, 1'h1);
      @(posedge clk_in);
      msg_ok <= 1'h1;
      repeat (10) @(posedge clk_in);
      msg_ok <= 1'h0;
      dev_rd(REG_STATUS);
      chk8(d & 8'h87, 8'h04);
      chk1(rx400, 1'h1);
      // base power-up, strap moved later, wake pattern, session
      sw_write(HREG_CTRL, 8'h01);
      dev_reset();
      dev_rd(REG_STATUS);
      chk8(d, st(1'h1, 1'h1, ST_BASE_IDLE));
      chk1(mac_run, 1'h1);
      sw_write(HREG_CTRL, 8'h00);
      repeat (10) @(posedge clk_in);
      chk1(mode_base, 1'h1);
      dev_rd(REG_STATUS);
      chk8(d, st(1'h1, 1'h1, ST_BASE_IDLE));
      dev_wr(REG_CTRL, 8'h03);
      repeat (50) @(posedge clk_in);
      for (int i = 0; i < 8; i++)
      begin
         #1;
         chk1(ook, OOK_PATTERN[i]);
         repeat (OOK_BIT_CYC) @(posedge clk_in);
      end
      chk1(tx400 & rx400, 1'h1);
      dev_rd(REG_STATUS);
      chk8(d, st(1'h1, 1'h1, ST_BASE_WAKE));
      dev_wr(REG_CTRL, 8'h05);
      dev_rd(REG_STATUS);
      chk8(d, st(1'h1, 1'h1, ST_SESSION));
      chk1(ook, 1'h0);
      dev_wr(REG_CTRL, 8'h09);
      dev_rd(REG_STATUS);
      chk8(d, st(1'h1, 1'h1, ST_BASE_IDLE));
      end_of_test();
   end
endmodule : tb_top
